// >>> hdl/target_frame_pkg.sv
package target_frame_pkg;

	// Register offsets and reset values
	localparam logic [7:0] PKT_CTRL_ADDR  = 8'h1b;
	localparam logic [7:0] CARD_TIME_ADDR = 8'h1c;
	localparam logic [7:0] PKT_CTRL_RST   = 8'h00;
	localparam logic [7:0] CARD_TIME_RST  = 8'h62;

	// Field positions
	localparam int WAIT_SEL_BIT   = 7;
	localparam int HALF_SLOT_BIT  = 6;
	localparam int MAX_LEN_HI     = 5;
	localparam int MAX_LEN_LO     = 0;
	localparam int SENS_HI        = 7;
	localparam int SENS_LO        = 5;
	localparam int TAU_HI         = 4;
	localparam int TAU_LO         = 3;
	localparam int HALT_BIT       = 2;
	localparam int EXT_HI         = 1;
	localparam int EXT_LO         = 0;

	// Length limit: field times four, zero means 256 bytes
	localparam int          LEN_SCALE_SHIFT = 2;
	localparam logic [8:0]  LEN_ZERO_LIMIT  = 9'h100;
	localparam logic [8:0]  LEN_COUNT_MAX   = 9'h1ff;
	// Minimum response time base, in data bits
	localparam logic [3:0]  RESP_BASE_BITS  = 4'h7;
	// Request code accepted while halted
	localparam logic [7:0]  HALT_REQ_CODE   = 8'h52;

	typedef enum logic [1:0] {
		RATE_106,
		RATE_212,
		RATE_424,
		RATE_848
	} link_rate_e;

	typedef struct packed {
		logic [2:0] miller_sensitivity;
		logic [1:0] miller_time_constant;
		logic       half_slot;
		logic       active_allowed;
	} tuning_s;

	typedef struct packed {
		logic       frame_start;
		logic       byte_valid;
		logic [7:0] byte_data;
		logic       frame_end;
		logic       frame_ok;
		logic       select_done;
		logic       polling_done;
	} rx_event_s;

endpackage

// >>> hdl/bit_gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts data-bit ticks since the last received frame end
module bit_gap_timer #(
	parameter int W = 4
) (
	input  wire logic         clock_in,  // Clock
	input  wire logic         rst_in,    // Async reset
	input  wire logic         ce_in,     // Clock enable
	input  wire logic         restart_in, // Frame end
	input  wire logic         tick_in,   // One data bit
	input  wire logic [W-1:0] limit_in,  // Bits to wait
	output logic              done_out   // Limit reached
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         done_reg;
	logic         done_next;

	always_comb
	begin
		cnt_next  = cnt_reg;
		done_next = done_reg;
		if (restart_in)
		begin
			cnt_next  = '0;
			done_next = 1'b0;
		end
		else if (tick_in && !done_reg)
		begin
			cnt_next  = cnt_reg + 1'b1;
			done_next = ((cnt_reg + 1'b1) >= limit_in);
		end
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_reg  <= '0;
			done_reg <= 1'b1;
		end
		else if (ce_in)
		begin
			cnt_reg  <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign done_out = done_reg;
endmodule
`default_nettype wire

// >>> hdl/target_frame_settings.sv
`timescale 1ns/1ps
`default_nettype none
module target_frame_settings
	import target_frame_pkg::*;
(
	input  wire logic                  clock_in,       // 200 MHz clock
	input  wire logic                  rst_in,         // Async reset
	input  wire logic                  ce_in,          // Clock enable
	input  wire logic [7:0]            addr_in,        // Register address
	input  wire logic [7:0]            wdata_in,       // Write data
	input  wire logic                  wr_in,          // Write strobe
	input  wire logic                  rd_in,          // Read strobe
	output logic [7:0]                 rdata_out,      // Read data
	input  wire target_frame_pkg::link_rate_e rate_in, // Link rate
	input  wire logic                  sync_detect_enable_in, // Sync detect
	input  wire logic                  card_mode_in,   // Card operation
	input  wire logic                  bit_tick_in,    // Data-bit tick
	input  wire target_frame_pkg::rx_event_s rx_in,    // Receive events
	input  wire logic                  halt_set_in,    // State machine halt
	input  wire logic                  rf_reset_in,    // RF reset
	input  wire logic                  anticoll_busy_in, // Anticollision runs
	input  wire logic                  tx_start_in,    // Host starts frame
	input  wire logic                  bit_aligned_in, // Bit phase correct
	output var target_frame_pkg::tuning_s tuning_out, // Decoder settings
	output logic                       anticoll_end_out, // End anticollision
	output logic                       pkt_drop_out,   // Packet discarded
	output logic                       pkt_accept_out, // Packet accepted
	output logic                       req_ignore_out, // Request ignored
	output logic                       tx_go_out       // Transmit begins
);
	logic [7:0] pkt_ctrl_reg, pkt_ctrl_next;
	logic [7:0] card_time_reg, card_time_next;
	logic [7:0] rdata_reg, rdata_next;

	// Register file
	always_comb
	begin
		pkt_ctrl_next  = pkt_ctrl_reg;
		card_time_next = card_time_reg;
		rdata_next     = 8'h00;
		if (wr_in && addr_in == PKT_CTRL_ADDR)
			pkt_ctrl_next = wdata_in;
		if (wr_in && addr_in == CARD_TIME_ADDR)
			card_time_next = wdata_in;
		// Set wins over RF-reset clear so an entering halt is not lost
		if (rf_reset_in)
			card_time_next[HALT_BIT] = 1'b0;
		if (halt_set_in)
			card_time_next[HALT_BIT] = 1'b1;
		if (rd_in)
		begin
			case (addr_in)
				PKT_CTRL_ADDR:  rdata_next = pkt_ctrl_reg;
				CARD_TIME_ADDR: rdata_next = card_time_reg;
				default:        rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pkt_ctrl_reg  <= PKT_CTRL_RST;
			card_time_reg <= CARD_TIME_RST;
			rdata_reg     <= 8'h00;
		end
		else if (ce_in)
		begin
			pkt_ctrl_reg  <= pkt_ctrl_next;
			card_time_reg <= card_time_next;
			rdata_reg     <= rdata_next;
		end
	end
	assign rdata_out = rdata_reg;

	logic wait_sel;
	logic [5:0] max_len;
	logic [1:0] resp_ext;
	assign wait_sel = pkt_ctrl_reg[WAIT_SEL_BIT];
	assign max_len  = pkt_ctrl_reg[MAX_LEN_HI:MAX_LEN_LO];
	assign resp_ext = card_time_reg[EXT_HI:EXT_LO];

	// Tuning outputs, registered
	tuning_s tuning_reg, tuning_next;
	always_comb
	begin
		tuning_next.miller_sensitivity   = card_time_reg[SENS_HI:SENS_LO];
		tuning_next.miller_time_constant = card_time_reg[TAU_HI:TAU_LO];
		tuning_next.half_slot = (rate_in == RATE_424)
			&& pkt_ctrl_reg[HALF_SLOT_BIT];
		tuning_next.active_allowed = !wait_sel;
	end

	// Receive length check and selection tracking
	logic [8:0] len_reg, len_next;
	logic [8:0] limit;
	logic       no_limit;
	logic       selected_reg, selected_next;
	logic       drop_reg, drop_next;
	logic       accept_reg, accept_next;
	logic       end_reg, end_next;
	logic       ign_reg, ign_next;
	logic       first_reg, first_next;

	always_comb
	begin
		limit = (max_len == 6'h00) ? LEN_ZERO_LIMIT
			: 9'(max_len) << LEN_SCALE_SHIFT;
		no_limit = (rate_in == RATE_106) && !sync_detect_enable_in;
	end

	always_comb
	begin
		len_next      = len_reg;
		selected_next = selected_reg;
		drop_next     = 1'b0;
		accept_next   = 1'b0;
		end_next      = 1'b0;
		ign_next      = 1'b0;
		first_next    = first_reg;
		if (rx_in.frame_start)
		begin
			len_next   = 9'h000;
			first_next = 1'b1;
		end
		if (rx_in.byte_valid)
		begin
			if (len_reg != LEN_COUNT_MAX)
				len_next = len_reg + 9'h001;
			first_next = 1'b0;
			// Halted card at 106 kbit only answers the wake-up code
			if (first_reg && card_mode_in && rate_in == RATE_106
				&& card_time_reg[HALT_BIT]
				&& rx_in.byte_data != HALT_REQ_CODE)
				ign_next = 1'b1;
		end
		if (rx_in.frame_end)
		begin
			// Drop wins over accept so an over-long frame is never reported good
			if (!no_limit && len_reg > limit)
				drop_next = 1'b1;
			else if (rx_in.frame_ok)
			begin
				accept_next = 1'b1;
				// With wait_sel set, end only once a select or polling has been seen
				if (anticoll_busy_in && (!wait_sel || selected_reg))
					end_next = 1'b1;
			end
		end
		if (rx_in.select_done || rx_in.polling_done)
			selected_next = 1'b1;
		if (!anticoll_busy_in || rf_reset_in)
			selected_next = 1'b0;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			len_reg      <= 9'h000;
			selected_reg <= 1'b0;
			drop_reg     <= 1'b0;
			accept_reg   <= 1'b0;
			end_reg      <= 1'b0;
			ign_reg      <= 1'b0;
			first_reg    <= 1'b0;
			tuning_reg   <= '0;
		end
		else if (ce_in)
		begin
			len_reg      <= len_next;
			selected_reg <= selected_next;
			drop_reg     <= drop_next;
			accept_reg   <= accept_next;
			end_reg      <= end_next;
			ign_reg      <= ign_next;
			first_reg    <= first_next;
			tuning_reg   <= tuning_next;
		end
	end

	// Minimum response time and transmit hold
	logic [3:0] resp_bits;
	logic       gap_done;
	logic       pend_reg, pend_next;
	logic       go_reg, go_next;
	assign resp_bits = RESP_BASE_BITS + {2'b00, resp_ext};

	// Timer leaves reset as done: no hold before the first received frame
	bit_gap_timer #(
		.W(4)
	) u_gap (
		.clock_in  (clock_in),
		.rst_in    (rst_in),
		.ce_in     (ce_in),
		.restart_in(rx_in.frame_end),
		.tick_in   (bit_tick_in),
		.limit_in  (resp_bits),
		.done_out  (gap_done)
	);

	always_comb
	begin
		pend_next = pend_reg;
		go_next   = 1'b0;
		if (tx_start_in)
			pend_next = 1'b1;
		// Hold until gap over, then start on a correct bit boundary
		if ((tx_start_in || pend_reg) && gap_done && bit_aligned_in)
		begin
			go_next   = 1'b1;
			pend_next = 1'b0;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pend_reg <= 1'b0;
			go_reg   <= 1'b0;
		end
		else if (ce_in)
		begin
			pend_reg <= pend_next;
			go_reg   <= go_next;
		end
	end

	assign tuning_out       = tuning_reg;
	assign anticoll_end_out = end_reg;
	assign pkt_drop_out     = drop_reg;
	assign pkt_accept_out   = accept_reg;
	assign req_ignore_out   = ign_reg;
	assign tx_go_out        = go_reg;

	// Assertions
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	halt_rf_clear_a: assert property (ce_in && rf_reset_in
		&& !halt_set_in |=> !card_time_reg[HALT_BIT])
		else $error("halt not cleared");
	halt_set_wins_a: assert property (ce_in && halt_set_in
		|=> card_time_reg[HALT_BIT]) else $error("halt set lost");
	no_active_sel_a: assert property (ce_in && wait_sel
		|=> !tuning_out.active_allowed) else $error("active allowed");
	slot_half_a: assert property (ce_in && rate_in != RATE_424
		|=> !tuning_out.half_slot) else $error("half slot off rate");
	// Sampled reset keeps the release edge from comparing reset values
	miller_sens_a: assert property (ce_in && !rst_in
		|=> tuning_out.miller_sensitivity
		== $past(card_time_reg[SENS_HI:SENS_LO])) else $error("sens");
	miller_tau_a: assert property (ce_in && !rst_in
		|=> tuning_out.miller_time_constant
		== $past(card_time_reg[TAU_HI:TAU_LO])) else $error("tau");
	len_drop_a: assert property (ce_in && rx_in.frame_end
		&& !no_limit && len_reg > limit |=> pkt_drop_out)
		else $error("long kept");
	zero_limit_a: assert property (max_len == 6'h00
		|-> limit == LEN_ZERO_LIMIT) else $error("zero limit");
	nolimit_keep_a: assert property (ce_in && rx_in.frame_end
		&& no_limit |=> !pkt_drop_out) else $error("drop w/o limit");
	wait_sel_end_a: assert property (anticoll_end_out
		&& $past(wait_sel) |-> $past(selected_reg))
		else $error("early end");
	end_accept_a: assert property (anticoll_end_out
		|-> pkt_accept_out) else $error("end without accept");
	tx_hold_a: assert property (tx_go_out |-> $past(gap_done))
		else $error("tx early");
	tx_late_go_a: assert property (ce_in && !rst_in && tx_start_in
		&& gap_done && bit_aligned_in |=> tx_go_out)
		else $error("late start held");
	resp_range_a: assert property (resp_bits >= RESP_BASE_BITS
		&& resp_bits <= RESP_BASE_BITS + 4'h3) else $error("resp");
	gap_restart_a: assert property (ce_in && rx_in.frame_end
		|=> !gap_done) else $error("gap not restarted");
	len_restart_a: assert property (ce_in && rx_in.frame_start
		&& !rx_in.byte_valid |=> len_reg == 9'h000)
		else $error("length not restarted");
	drop_accept_a: assert property (!(pkt_drop_out
		&& pkt_accept_out)) else $error("drop and accept");
	halt_ign_a: assert property (req_ignore_out
		|-> $past(card_time_reg[HALT_BIT])) else $error("bad ignore");

	tx_go_c: cover property (tx_start_in ##[1:40] tx_go_out);
	drop_c: cover property (pkt_drop_out);
	accept_c: cover property (pkt_accept_out);
	end_c: cover property (anticoll_end_out);
	ign_c: cover property (req_ignore_out);
endmodule
`default_nettype wire

// >>> test/reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module reader_model
	import target_frame_pkg::*;
(
	input  wire logic clock_in, // Clock
	output logic      tick_out, // Data-bit tick
	output var rx_event_s rx_out // Receive events
);
	int ph = 0;
	initial
	begin
		tick_out = 1'b0;
		rx_out = '0;
	end
	// One data bit every four clocks keeps the gap timing short
	always @(posedge clock_in)
	begin
		ph <= (ph + 1) % 4;
		tick_out <= (ph == 3);
	end
	// Idle data keeps changing, so a stale byte cannot pass
	// A sel of 1 sends a select, 2 a polling, before the frame
	task automatic send(input int n, input logic [7:0] b0, input int sel);
		if (sel != 0)
		begin
			@(posedge clock_in);
			rx_out <= '{select_done: (sel == 1), polling_done: (sel == 2),
				byte_data: 8'($urandom), default: '0};
		end
		@(posedge clock_in);
		rx_out <= '{frame_start: 1'b1, byte_data: 8'($urandom), default: '0};
		for (int i = 0; i < n; i++)
		begin
			@(posedge clock_in);
			rx_out <= '{byte_valid: 1'b1,
				byte_data: (i == 0) ? b0 : 8'($urandom), default: '0};
		end
		@(posedge clock_in);
		rx_out <= '{frame_end: 1'b1, frame_ok: 1'b1, default: '0};
		@(posedge clock_in);
		rx_out <= '{byte_data: 8'($urandom), default: '0};
	endtask
endmodule
`default_nettype wire

// >>> test/test_target_frame_settings.sv
`timescale 1ns/1ps
`default_nettype none
module test_target_frame_settings;
	import target_frame_pkg::*;
	logic       ce, clk, rst, wr, rd, sync, card, hset, rfr, busy, txs, algn;
	logic       tick, aend, drop, acc, ign, go;
	logic [7:0] addr, wdata, rdata, v1, v2;
	link_rate_e rate;
	rx_event_s  rx;
	tuning_s    tun;
	int n_fail = 0, total_checks = 0;
	int c_end = 0, c_drop = 0, c_acc = 0, c_ign = 0, c_go = 0;
	int tk = 0, tk_go = 0, f, e, g;
	target_frame_settings i_target_frame_settings (.clock_in(clk),
		.rst_in(rst), .ce_in(ce), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rate_in(rate),
		.sync_detect_enable_in(sync), .card_mode_in(card),
		.bit_tick_in(tick), .rx_in(rx), .halt_set_in(hset),
		.rf_reset_in(rfr), .anticoll_busy_in(busy), .tx_start_in(txs),
		.bit_aligned_in(algn), .tuning_out(tun), .anticoll_end_out(aend),
		.pkt_drop_out(drop), .pkt_accept_out(acc), .req_ignore_out(ign),
		.tx_go_out(go));
	reader_model i_reader_model (.clock_in(clk), .tick_out(tick),
		.rx_out(rx));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		c_end <= c_end + int'(aend === 1'b1);
		c_drop <= c_drop + int'(drop === 1'b1);
		c_acc <= c_acc + int'(acc === 1'b1);
		c_ign <= c_ign + int'(ign === 1'b1);
		c_go <= c_go + int'(go === 1'b1);
		tk <= (rx.frame_end === 1'b1) ? 0 : tk + int'(tick === 1'b1);
		if (go === 1'b1)
			tk_go <= tk;
	end
	task automatic chk8(input string s, input logic [7:0] x, input logic [7:0] v);
		total_checks++;
		if (v !== x)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", s, x, v);
		end
	endtask
	task automatic chkn(input string s, input int x, input int v);
		total_checks++;
		if (v != x)
		begin
			n_fail++;
			$display("mismatch %s expected %0d seen %0d", s, x, v);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk8("rdata", x, rdata);
	endtask
	// A negative expected accept count skips that comparison
	task automatic fr(input int n, input logic [7:0] b0, input int sel,
		input int xa, input int xd, input int xi, input int xe);
		int a, d, i, en;
		a = c_acc;
		d = c_drop;
		i = c_ign;
		en = c_end;
		i_reader_model.send(n, b0, sel);
		repeat (3) @(posedge clk);
		if (xa >= 0)
			chkn("accept", xa, c_acc - a);
		chkn("drop", xd, c_drop - d);
		chkn("ignore", xi, c_ign - i);
		chkn("anticoll_end", xe, c_end - en);
	endtask
	task automatic pulse_tx();
		@(posedge clk);
		txs <= 1'b1;
		@(posedge clk);
		txs <= 1'b0;
	endtask
	// Longest accepted payload for a max-length field value
	function automatic int len_limit(input int fld);
		return (fld == 0) ? 256 : 4 * fld;
	endfunction
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#(40000 * 5);
		n_fail++;
		test_done();
	end
	initial
	begin
		{ce, rst, wr, rd, sync, card, hset, rfr, busy, txs, algn} = 11'h600;
		addr = 8'h00;
		wdata = 8'h00;
		rate = RATE_424;
		void'($urandom(83711));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rchk(PKT_CTRL_ADDR, PKT_CTRL_RST);
		rchk(CARD_TIME_ADDR, CARD_TIME_RST);
		wreg(8'h1d, 8'hff);
		rchk(8'h1d, 8'h00);
		rchk(PKT_CTRL_ADDR, PKT_CTRL_RST);
		// A write while the clock enable is low must leave no trace
		ce <= 1'b0;
		wreg(PKT_CTRL_ADDR, 8'h3f);
		ce <= 1'b1;
		rchk(PKT_CTRL_ADDR, PKT_CTRL_RST);
		repeat (4)
		begin
			v1 = 8'($urandom);
			v2 = 8'($urandom) & 8'hfb;
			wreg(PKT_CTRL_ADDR, v1);
			wreg(CARD_TIME_ADDR, v2);
			rchk(PKT_CTRL_ADDR, v1);
			rchk(CARD_TIME_ADDR, v2);
			chk8("sens", {5'h0, v2[7:5]}, {5'h0, tun.miller_sensitivity});
			chk8("tau", {6'h0, v2[4:3]}, {6'h0, tun.miller_time_constant});
			chk8("slot", {7'h0, v1[6]}, {7'h0, tun.half_slot});
			chk8("active", {7'h0, ~v1[7]}, {7'h0, tun.active_allowed});
		end
		$display("test registers done");
		rate <= RATE_212;
		sync <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			f = (k == 0) ? 0 : ((k == 1) ? 1 + $urandom % 62 : 63);
			wreg(PKT_CTRL_ADDR, 8'(f));
			e = len_limit(f);
			fr(e, 8'h00, 0, 1, 0, 0, 0);
			fr(e + 1, 8'h00, 0, 0, 1, 0, 0);
		end
		wreg(PKT_CTRL_ADDR, 8'h01);
		rate <= RATE_106;
		sync <= 1'b0;
		fr(9, 8'h00, 0, 1, 0, 0, 0);
		sync <= 1'b1;
		fr(9, 8'h00, 0, 0, 1, 0, 0);
		$display("test length done");
		busy <= 1'b1;
		wreg(PKT_CTRL_ADDR, 8'h80);
		fr(4, 8'h00, 0, 1, 0, 0, 0);
		fr(4, 8'h00, 1, 1, 0, 0, 1);
		busy <= 1'b0;
		fr(4, 8'h00, 0, 1, 0, 0, 0);
		busy <= 1'b1;
		fr(4, 8'h00, 0, 1, 0, 0, 0);
		fr(4, 8'h00, 2, 1, 0, 0, 1);
		wreg(PKT_CTRL_ADDR, 8'h00);
		fr(4, 8'h00, 0, 1, 0, 0, 1);
		busy <= 1'b0;
		$display("test anticollision done");
		card <= 1'b1;
		wreg(CARD_TIME_ADDR, 8'h04);
		fr(2, 8'h26, 0, -1, 0, 1, 0);
		fr(2, HALT_REQ_CODE, 0, -1, 0, 0, 0);
		@(posedge clk);
		rfr <= 1'b1;
		@(posedge clk);
		rfr <= 1'b0;
		rchk(CARD_TIME_ADDR, 8'h00);
		fr(2, 8'h26, 0, -1, 0, 0, 0);
		@(posedge clk);
		hset <= 1'b1;
		@(posedge clk);
		hset <= 1'b0;
		rchk(CARD_TIME_ADDR, 8'h04);
		card <= 1'b0;
		$display("test halt done");
		algn <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			wreg(CARD_TIME_ADDR, 8'(k));
			i_reader_model.send(2, 8'h00, 0);
			g = c_go;
			pulse_tx();
			for (int i = 0; i < 200 && c_go == g; i++)
			begin
				@(posedge clk);
				#1;
			end
			chkn("resp_bits", 7 + k, tk_go);
		end
		for (int i = 0; i < 200 && tk < 12; i++)
			@(posedge clk);
		g = c_go;
		pulse_tx();
		@(posedge clk);
		#1;
		chkn("late_go_now", g + 1, c_go);
		g = c_go;
		algn <= 1'b0;
		pulse_tx();
		repeat (6) @(posedge clk);
		chkn("late_hold", g, c_go);
		algn <= 1'b1;
		repeat (4) @(posedge clk);
		chkn("late_go", g + 1, c_go);
		$display("test response done");
		test_done();
	end
endmodule
`default_nettype wire
